// *** design/esps_defines.vh ***
`ifndef ESPS_DEFINES_VH
`define ESPS_DEFINES_VH
// Instruction slot count and general register count
`define ESPS_SLOTS 32
`define ESPS_GREGS 16
// Program image, slots 0..7; the remaining slots hold zero
`define ESPS_I0 16'h0400
`define ESPS_I1 16'h3180
`define ESPS_I2 16'h2680
`define ESPS_I3 16'h7170
`define ESPS_I4 16'h7122
`define ESPS_I5 16'h8020
`define ESPS_I6 16'h2530
`define ESPS_I7 16'hf000
// Opcode field, top nibble
`define ESPS_OP_MOVB_ST 4'h0
`define ESPS_OP_MOVW_ST 4'h2
`define ESPS_OP_MOVW_LD 4'h3
`define ESPS_OP_ALU 4'h7
`define ESPS_OP_BC 4'h8
`define ESPS_OP_FINISH 4'hf
// ALU sub-op in bits 3:0
`define ESPS_ALU_ADD 4'h0
`define ESPS_ALU_CMP 4'h2
// Pointer step and general register roles
`define ESPS_STEP 16'h0002
`define ESPS_G_ZERO 4'h0
`define ESPS_G_PTR 4'h1
`define ESPS_G_END 4'h2
`define ESPS_G_START 4'h3
`define ESPS_G_ITLS 4'h4
`define ESPS_G_PTRA 4'h5
`define ESPS_G_DUTY 4'h6
`define ESPS_G_TWO 4'h7
`define ESPS_G_DATA 4'h8
`define ESPS_G_ONES 4'hf
// Timing: clock 40 MHz
`define ESPS_CLK_HZ 40000000
`define ESPS_INTERVAL_MS 125
`define ESPS_PERIOD_MS 1
`define ESPS_INTERVAL_CYC ((`ESPS_CLK_HZ / 1000) * `ESPS_INTERVAL_MS)
`define ESPS_PERIOD_CYC ((`ESPS_CLK_HZ / 1000) * `ESPS_PERIOD_MS)
// Default duty step count
`define ESPS_DUTY_STEPS 32
`endif

// *** design/esps_buf2.v ***
`timescale 1ns/1ps
`default_nettype none
// Two-entry skid buffer; input ready depends only on occupancy
module esps_buf2 #(
  parameter W = 16
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [W-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [W-1:0] out_data_out
);
  reg [W-1:0] mem_r [0:1];
  reg wp_r;
  reg rp_r;
  reg [1:0] cnt_r;
  wire push;
  wire pop;

  assign in_ready_out = (cnt_r != 2'd2);
  assign out_valid_out = (cnt_r != 2'd0);
  assign out_data_out = mem_r[rp_r];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // Pointers and occupancy
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'd0;
    end else begin
      if (push) wp_r <= ~wp_r;
      if (pop) rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  // Storage has no reset; reads only happen when valid
  always @(posedge clk_in) begin
    if (push) mem_r[wp_r] <= in_data_in;
  end
endmodule
`default_nettype wire

// *** design/esps_top.v ***
`include "esps_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module esps_top #(
  parameter INTERVAL_CYC = `ESPS_INTERVAL_CYC,
  parameter PERIOD_CYC = `ESPS_PERIOD_CYC,
  parameter PRESCALE = 128,
  parameter STEPS = `ESPS_DUTY_STEPS,
  parameter TBL_AW = 6
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // Sequencer launch and table fill
  input wire start_in,
  input wire [15:0] tbl_start_in,
  input wire tbl_wr_in,
  input wire [15:0] tbl_addr_in,
  input wire [15:0] tbl_data_in,
  // Status and PWM channel
  output reg busy_out,
  output reg interval_flag_out,
  output reg [15:0] ptr_out,
  output reg [15:0] duty_out,
  output reg pwm_out
);
  // Addresses that the program stores to; they decode inside the block
  localparam [15:0] ST_ADDR = 16'hff00;
  localparam [15:0] PTRA_ADDR = 16'hff02;
  localparam [15:0] DUTY_ADDR = 16'hff04;
  // One-hot sequencer states
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_FETCH = 6'h02;
  localparam [5:0] S_EXEC = 6'h04;
  localparam [5:0] S_LOAD = 6'h08;
  localparam [5:0] S_WAIT = 6'h10;
  localparam [5:0] S_STOP = 6'h20;
  // Smallest prescale that lets a sixteen-bit count span the interval
  localparam integer PRE_DIV = INTERVAL_CYC / 65536 + 1;
  localparam integer ITV_TOP_I = (INTERVAL_CYC / PRE_DIV) - 1;
  localparam [15:0] ITV_TOP = ITV_TOP_I[15:0];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Program slots, general registers and the duty table
  reg [15:0] slot_r [0:`ESPS_SLOTS-1];
  reg [15:0] greg_r [0:`ESPS_GREGS-1];
  reg [15:0] tbl_r [0:(1<<TBL_AW)-1];
  // Sequencer state
  reg [5:0] state_r;
  reg [4:0] pc_r;
  reg [15:0] ir_r;
  reg carry_r;
  // Interval and period counters
  reg [31:0] pre_r;
  reg [15:0] itv_r;
  reg [31:0] pwm_cnt_r;
  // Load holding register and slave compare stage
  reg [15:0] ld_r;
  reg slave_r;
  integer i;

  // Duty word handshake into the buffer
  wire duty_valid;
  wire duty_ready;
  wire [15:0] duty_data;
  reg duty_push;
  reg [15:0] duty_word;

  // ----------------------------------------------------------------
  // Program image and address helpers
  // ----------------------------------------------------------------
  // Program image decode; slots 8..31 are zero
  function [15:0] esps_rom;
    input [4:0] idx;
    begin
      case (idx)
        5'd0: esps_rom = `ESPS_I0;
        5'd1: esps_rom = `ESPS_I1;
        5'd2: esps_rom = `ESPS_I2;
        5'd3: esps_rom = `ESPS_I3;
        5'd4: esps_rom = `ESPS_I4;
        5'd5: esps_rom = `ESPS_I5;
        5'd6: esps_rom = `ESPS_I6;
        5'd7: esps_rom = `ESPS_I7;
        default: esps_rom = 16'h0000;
      endcase
    end
  endfunction

  // Table word address from a byte pointer
  function [TBL_AW-1:0] esps_widx;
    input [15:0] a;
    begin
      esps_widx = a[TBL_AW:1];
    end
  endfunction

  // ----------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------
  // Opcode on top, then address or first register, then data or second
  // register; the low nibble picks the arithmetic operation or is unused
  wire [3:0] op = ir_r[15:12];
  wire [3:0] fa = ir_r[11:8];
  wire [3:0] fb = ir_r[7:4];
  wire [3:0] fs = ir_r[3:0];
  wire [15:0] va = greg_r[fa];
  wire [15:0] vb = greg_r[fb];
  wire [16:0] sum = {1'b0, va} + {1'b0, vb};

  // ----------------------------------------------------------------
  // Duty table RAM
  // ----------------------------------------------------------------
  // Filled from outside at any time; no reset, so a write is one port
  always @(posedge clk_in) begin
    if (tbl_wr_in) tbl_r[esps_widx(tbl_addr_in)] <= tbl_data_in;
  end

  // ----------------------------------------------------------------
  // Interval timer: prescaled 16-bit counter
  // ----------------------------------------------------------------
  // Prescaler fitted so the sixteen-bit counter covers the interval
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_r <= 32'h0000_0000;
      itv_r <= 16'h0000;
    end else if (pre_r == PRE_DIV - 1) begin
      pre_r <= 32'h0000_0000;
      if (itv_r == ITV_TOP) itv_r <= 16'h0000;
      else itv_r <= itv_r + 16'h0001;
    end else begin
      pre_r <= pre_r + 32'h0000_0001;
    end
  end
  // One cycle wide expiry strobe
  wire itv_hit = (pre_r == PRE_DIV - 1) && (itv_r == ITV_TOP);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Status clear from the program loses to a new expiry
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= S_IDLE;
      pc_r <= 5'd0;
      ir_r <= 16'h0000;
      carry_r <= 1'b0;
      busy_out <= 1'b0;
      interval_flag_out <= 1'b0;
      ld_r <= 16'h0000;
      for (i = 0; i < `ESPS_SLOTS; i = i + 1) slot_r[i] <= 16'h0000;
      for (i = 0; i < `ESPS_GREGS; i = i + 1) greg_r[i] <= 16'h0000;
    end else begin
      if (itv_hit) interval_flag_out <= 1'b1;
      case (state_r)
        // Idle until software launches the sequencer
        S_IDLE: begin
          busy_out <= 1'b0;
          if (start_in) begin
            // Load the program and the pointer roles
            for (i = 0; i < `ESPS_SLOTS; i = i + 1) slot_r[i] <= esps_rom(i[4:0]);
            greg_r[`ESPS_G_ZERO] <= 16'h0000;
            greg_r[`ESPS_G_PTR] <= tbl_start_in;
            greg_r[`ESPS_G_END] <= tbl_start_in + {STEPS[14:0], 1'b0};
            greg_r[`ESPS_G_START] <= tbl_start_in;
            greg_r[`ESPS_G_ITLS] <= ST_ADDR;
            greg_r[`ESPS_G_PTRA] <= PTRA_ADDR;
            greg_r[`ESPS_G_DUTY] <= DUTY_ADDR;
            greg_r[`ESPS_G_TWO] <= `ESPS_STEP;
            greg_r[`ESPS_G_ONES] <= 16'hffff;
            state_r <= S_STOP;
          end
        end
        S_STOP: begin
          // Standby; each expiry launches one pass from slot zero
          if (itv_hit || interval_flag_out) begin
            pc_r <= 5'd0;
            busy_out <= 1'b1;
            state_r <= S_FETCH;
          end
        end
        // Fetch one slot and step the slot counter
        S_FETCH: begin
          ir_r <= slot_r[pc_r];
          pc_r <= pc_r + 5'd1;
          state_r <= S_EXEC;
        end
        // Execute; all but a load or a duty store take one cycle
        S_EXEC: begin
          state_r <= S_FETCH;
          case (op)
            `ESPS_OP_MOVB_ST: begin
              // Byte store; only the interval status address is decoded
              if (va == ST_ADDR && !itv_hit) interval_flag_out <= vb[0];
            end
            `ESPS_OP_MOVW_LD: begin
              // Word load through the pointer register
              ld_r <= tbl_r[esps_widx(va)];
              state_r <= S_LOAD;
            end
            `ESPS_OP_MOVW_ST: begin
              // Word store to the duty register or to the pointer register
              if (va == DUTY_ADDR) state_r <= S_WAIT;
              else if (va == PTRA_ADDR) greg_r[`ESPS_G_PTR] <= vb;
            end
            `ESPS_OP_ALU: begin
              // Add writes back; compare only sets the borrow for the branch
              if (fs == `ESPS_ALU_ADD) greg_r[fa] <= sum[15:0];
              else if (fs == `ESPS_ALU_CMP) carry_r <= (va < vb);
            end
            `ESPS_OP_BC: begin
              // Offset counts from the branch slot; pc_r already points past it
              if (carry_r) pc_r <= pc_r + {1'b0, ir_r[7:4]} - 5'd1;
            end
            `ESPS_OP_FINISH: begin
              // Every general register is kept for the next pass
              busy_out <= 1'b0;
              state_r <= S_STOP;
            end
            default: state_r <= S_FETCH;
          endcase
        end
        // Load result lands in the named register a cycle later
        S_LOAD: begin
          greg_r[fb] <= ld_r;
          state_r <= S_FETCH;
        end
        S_WAIT: begin
          // Stall until the buffer accepts the duty word
          if (duty_ready) state_r <= S_FETCH;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Duty store offers its data register to the buffer while waiting
  always @* begin
    duty_push = (state_r == S_WAIT);
    duty_word = vb;
  end

  // ----------------------------------------------------------------
  // Duty path buffer to the slave channel
  // ----------------------------------------------------------------
  // Slave channel takes a new word only as the master period ends
  wire duty_take = (pwm_cnt_r == PERIOD_CYC - 1);
  esps_buf2 #(.W(16)) u_esps_buf2 (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(duty_push),
    .in_ready_out(duty_ready),
    .in_data_in(duty_word),
    .out_valid_out(duty_valid),
    .out_ready_in(duty_take),
    .out_data_out(duty_data)
  );

  // ----------------------------------------------------------------
  // PWM master period and slave duty
  // ----------------------------------------------------------------
  // Duty changes only at period end so no pulse is torn
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pwm_cnt_r <= 32'h0000_0000;
      duty_out <= 16'h0000;
      pwm_out <= 1'b0;
      ptr_out <= 16'h0000;
      slave_r <= 1'b0;
    end else begin
      // Pointer shown one cycle late for status
      ptr_out <= greg_r[`ESPS_G_PTR];
      if (duty_take) begin
        pwm_cnt_r <= 32'h0000_0000;
        if (duty_valid) duty_out <= duty_data;
      end else begin
        pwm_cnt_r <= pwm_cnt_r + 32'h0000_0001;
      end
      // Registered compare; the extra stage keeps the pin free of glitches
      slave_r <= (pwm_cnt_r < {16'h0000, duty_out} * PRESCALE / 4);
      pwm_out <= slave_r;
    end
  end
endmodule
`default_nettype wire

// *** tb/esps_top_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module esps_top_props #(parameter int STEPS = 32) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic [15:0] tbl_start_in,
  input wire logic tbl_wr_in,
  input wire logic [15:0] tbl_addr_in,
  input wire logic [15:0] tbl_data_in,
  input wire logic busy_out,
  input wire logic interval_flag_out,
  input wire logic [15:0] ptr_out,
  input wire logic [15:0] duty_out,
  input wire logic pwm_out
);
  logic armed_r, started_r, busy_d_r;
  logic [15:0] ptr0_r;
  wire [15:0] end_w = tbl_start_in + 16'(2 * STEPS);
  wire [15:0] adv_w = ptr0_r + 16'h0002;
  wire [15:0] nxt_w = (adv_w >= end_w) ? tbl_start_in : adv_w;
  // Pointer is latched as a pass opens, so the lagging output cannot mislead
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      armed_r <= 1'b0; started_r <= 1'b0; busy_d_r <= 1'b0; ptr0_r <= 16'h0000;
    end else begin
      busy_d_r <= busy_out;
      if (start_in) armed_r <= 1'b1;
      if (busy_out) started_r <= 1'b1;
      if (busy_out && !busy_d_r) ptr0_r <= ptr_out;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_no_early; !armed_r |-> !busy_out; endproperty
  a_no_early: assert property (p_no_early) else $error("pass before start");
  property p_flag_start; started_r && $rose(interval_flag_out) |-> ##[0:3] busy_out; endproperty
  a_flag_start: assert property (p_flag_start) else $error("expiry left idle");
  property p_clear; $rose(busy_out) |-> ##[0:4] !interval_flag_out; endproperty
  a_clear: assert property (p_clear) else $error("status not cleared");
  property p_pass_len; $rose(busy_out) |-> ##[8:60] $fell(busy_out); endproperty
  a_pass_len: assert property (p_pass_len) else $error("pass length wrong");
  property p_ptr_step; $fell(busy_out) |-> ##2 ptr_out == nxt_w; endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer step wrong");
  property p_idle_keep; (started_r && !busy_out) [*3] |-> $stable(ptr_out); endproperty
  a_idle_keep: assert property (p_idle_keep) else $error("pointer moved idle");
  property p_ptr_range;
    started_r |-> ptr_out >= tbl_start_in && ptr_out <= end_w && !ptr_out[0];
  endproperty
  a_ptr_range: assert property (p_ptr_range) else $error("pointer out of table");
  property p_pwm_zero; duty_out == 16'h0000 && $past(duty_out) == 16'h0000 |-> !pwm_out; endproperty
  a_pwm_zero: assert property (p_pwm_zero) else $error("output high at zero duty");
  c_wrap: cover property ($fell(busy_out) ##2 ptr_out == tbl_start_in);
  c_pwm: cover property ($rose(pwm_out));
  c_flag: cover property ($rose(interval_flag_out));
endmodule
`default_nettype wire

// *** tb/esps_sw_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Software side: fills the duty table before the sequencer is launched
// The processor interval interrupt stays masked: nothing here acts on the flag
module esps_sw_model #(parameter int FIRST = 4, parameter int STEPS = 4) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  output logic tbl_wr_out,
  output logic [15:0] tbl_addr_out,
  output logic [15:0] tbl_data_out,
  output logic done_out
);
  int seed = int'(32'hab826a85);
  // Used entries are distinct in turn so each duty change is visible; rest is random
  initial begin
    tbl_wr_out = 1'b0; tbl_addr_out = 16'h0000; tbl_data_out = 16'h0000; done_out = 1'b0;
    wait (rst_n_in === 1'b1);
    for (int i = 0; i < 32; i++) begin
      @(posedge clk_in);
      #1;
      tbl_wr_out = 1'b1;
      tbl_addr_out = 16'(2 * i);
      tbl_data_out = (i >= FIRST && i < FIRST + STEPS) ? 16'((i - FIRST + 1) % 4) : 16'($random(seed));
    end
    @(posedge clk_in);
    #1;
    tbl_wr_out = 1'b0;
    done_out = 1'b1;
  end
endmodule
`default_nettype wire

// *** tb/tb_esps_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_esps_top;
  localparam int STEPS = 4;
  localparam int IV = 2000;
  localparam int NPASS = 10;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic start_in = 1'b0;
  logic [15:0] tbl_start_in = 16'h0008;
  wire tbl_wr_in, load_done, busy_out, interval_flag_out, pwm_out;
  wire [15:0] tbl_addr_in, tbl_data_in, ptr_out, duty_out;
  int num_errors = 0;
  int compares = 0;
  logic [15:0] exp_ptr[$];
  logic [15:0] exp_duty[$];
  logic [15:0] last_duty = 16'h0000;
  always #12.5 clk_in = ~clk_in;
  esps_top #(.INTERVAL_CYC(IV), .PERIOD_CYC(100), .STEPS(STEPS)) u_esps_top (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .start_in(start_in), .tbl_start_in(tbl_start_in),
    .tbl_wr_in(tbl_wr_in), .tbl_addr_in(tbl_addr_in), .tbl_data_in(tbl_data_in),
    .busy_out(busy_out), .interval_flag_out(interval_flag_out), .ptr_out(ptr_out),
    .duty_out(duty_out), .pwm_out(pwm_out));
  esps_sw_model #(.FIRST(4), .STEPS(STEPS)) u_esps_sw_model (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .tbl_wr_out(tbl_wr_in), .tbl_addr_out(tbl_addr_in),
    .tbl_data_out(tbl_data_in), .done_out(load_done));
  task automatic test_done;
    if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Each duty change must match the oldest noted word
  always @(posedge clk_in) begin
    if (rst_n_in && duty_out !== last_duty) begin
      last_duty <= duty_out;
      check(duty_out, (exp_duty.size() != 0) ? exp_duty.pop_front() : ~duty_out, "duty");
    end
  end
  // Pointer lags a cycle, so it is read two edges after the pass ends
  always @(negedge busy_out) begin
    if (rst_n_in) begin
      repeat (2) @(posedge clk_in);
      #1;
      check(ptr_out, (exp_ptr.size() != 0) ? exp_ptr.pop_front() : ~ptr_out, "ptr");
    end
  end
  initial begin
    int p;
    repeat (8) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    for (int i = 0; i < 2000 && load_done !== 1'b1; i++) @(posedge clk_in);
    p = 8;
    for (int k = 0; k < NPASS; k++) begin
      exp_duty.push_back(16'(((p - 8) / 2 + 1) % 4));
      p = p + 2;
      if (p >= 8 + 2 * STEPS) p = 8;
      exp_ptr.push_back(16'(p));
    end
    @(posedge clk_in);
    #1 start_in = 1'b1;
    @(posedge clk_in);
    #1 start_in = 1'b0;
    for (int i = 0; i < (NPASS + 2) * IV && exp_ptr.size() != 0; i++) @(posedge clk_in);
    repeat (300) @(posedge clk_in);
    check(16'(exp_ptr.size() + exp_duty.size()), 16'h0000, "passes left");
    test_done();
  end
  // Guards against a hung sequencer; ten passes take about 20000 cycles
  initial begin
    #800000;
    num_errors++;
    test_done();
  end
endmodule
bind esps_top esps_top_props #(.STEPS(STEPS)) u_esps_top_props (.clk_in(clk_in),
  .rst_n_in(rst_n_in), .start_in(start_in), .tbl_start_in(tbl_start_in),
  .tbl_wr_in(tbl_wr_in), .tbl_addr_in(tbl_addr_in), .tbl_data_in(tbl_data_in),
  .busy_out(busy_out), .interval_flag_out(interval_flag_out), .ptr_out(ptr_out),
  .duty_out(duty_out), .pwm_out(pwm_out));
`default_nettype wire
